//--- hw/pbseq_pkg.sv
// Package of timing constants and states for the pushbutton power sequencer
package pbseq_pkg;
    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    localparam int CLK_HZ           = 50000000;
    localparam int TICK_US          = 1000;                       // Tick period in us
    localparam int TICK_CYC         = CLK_HZ / 1000000 * TICK_US; // Cycles per tick
    localparam int ON_DEBOUNCE_MS   = 32;
    localparam int OFF_DEBOUNCE_MS  = 32;
    localparam int INT_MIN_MS       = 32;
    localparam int BLANK_MS         = 512;
    localparam int LOCKOUT_MS       = 256;
    localparam int FORCED_OFF_MIN_MS = 64;
    localparam int KILL_FILT_US     = 30;
    localparam int KILL_FILT_CYC    = CLK_HZ / 1000000 * KILL_FILT_US;
    localparam int OSC_CYCLES       = 16;
    localparam logic EN_ACTIVE_HIGH = 1'h1;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        PBSEQ_IDLE    = 9'h001,
        PBSEQ_ON_DB   = 9'h002,
        PBSEQ_BLANK   = 9'h004,
        PBSEQ_REL_DB  = 9'h008,
        PBSEQ_RUN     = 9'h010,
        PBSEQ_OFF_DB  = 9'h020,
        PBSEQ_INT_MIN = 9'h040,
        PBSEQ_PD      = 9'h080,
        PBSEQ_LOCK    = 9'h100
    } pbseq_state_t;
endpackage : pbseq_pkg

//--- hw/pbseq_top.sv
// Pushbutton power sequencer: debounce, blanking, interrupt and forced shutdown
`timescale 1ns/1ps
`default_nettype none
module pbseq_top #(
    parameter int          TICK_CYC     = pbseq_pkg::TICK_CYC,
    parameter logic        EN_ACT_HIGH  = pbseq_pkg::EN_ACTIVE_HIGH,
    parameter int          OSC_CYCLES   = pbseq_pkg::OSC_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Pins from outside
    input  wire logic        push_in_n,
    input  wire logic        kill_in_n,
    // Timer extensions
    input  wire logic [15:0] on_delay_cap,
    input  wire logic        off_hold_cap,
    input  wire logic        off_hold_osc,
    // Outputs
    output logic             power_en,
    output logic             int_n
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] push_sync_r;
    logic [1:0] kill_sync_r;
    logic [1:0] osc_sync_r;
    logic       osc_prev_r;
    logic       push_prev_r;

    // Two flops per asynchronous input
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            push_sync_r <= 2'h3;
            kill_sync_r <= 2'h3;
            osc_sync_r  <= 2'h0;
            osc_prev_r  <= 1'h0;
            push_prev_r <= 1'h1; // Idle level of the button, no false edge
        end else begin
            push_sync_r <= {push_sync_r[0], push_in_n};
            kill_sync_r <= {kill_sync_r[0], kill_in_n};
            osc_sync_r  <= {osc_sync_r[0], off_hold_osc};
            osc_prev_r  <= osc_sync_r[1];
            push_prev_r <= push_sync_r[1];
        end
    end

    wire push_low  = ~push_sync_r[1];
    // A held button after lockout must not restart power
    wire push_fall = push_prev_r & ~push_sync_r[1];
    wire osc_rise = osc_sync_r[1] & ~osc_prev_r;

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    logic [19:0] tick_cnt_r;
    wire         tick = (tick_cnt_r == 20'(TICK_CYC - 1));

    // Shared timebase for every ms timer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) tick_cnt_r <= 20'h00000;
        else        tick_cnt_r <= tick ? 20'h00000 : tick_cnt_r + 20'h00001;
    end

    // ------------------------------------------------------------------
    // Shutdown input glitch filter
    // ------------------------------------------------------------------
    logic [10:0] kill_cnt_r;
    logic        kill_low_r;
    wire         kill_raw_low = ~kill_sync_r[1];
    wire         kill_full    = (kill_cnt_r == 11'(pbseq_pkg::KILL_FILT_CYC - 1));

    // Low must persist the filter time
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            kill_cnt_r <= 11'h000;
            kill_low_r <= 1'h0;
        end else if (!kill_raw_low) begin
            kill_cnt_r <= 11'h000;
            kill_low_r <= 1'h0;
        end else if (kill_full) begin
            kill_low_r <= 1'h1;
        end else begin
            kill_cnt_r <= kill_cnt_r + 11'h001;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    pbseq_pkg::pbseq_state_t state_r;
    pbseq_pkg::pbseq_state_t state_nxt;
    logic [16:0] ms_cnt_r;
    logic [4:0]  osc_cnt_r;
    logic        clr_timer;
    logic        on_r;
    logic        on_nxt;
    logic        int_r;
    logic        int_nxt;

    wire [16:0] on_target  = 17'(pbseq_pkg::ON_DEBOUNCE_MS) + {1'h0, on_delay_cap};
    wire        on_done    = (ms_cnt_r >= on_target);
    wire        blank_done = (ms_cnt_r >= 17'(pbseq_pkg::BLANK_MS));
    wire        rel_done   = (ms_cnt_r >= 17'(pbseq_pkg::ON_DEBOUNCE_MS));
    wire        off_done   = (ms_cnt_r >= 17'(pbseq_pkg::OFF_DEBOUNCE_MS));
    wire        imin_done  = (ms_cnt_r >= 17'(pbseq_pkg::INT_MIN_MS));
    wire        lock_done  = (ms_cnt_r >= 17'(pbseq_pkg::LOCKOUT_MS));
    // No extension: 64ms total hold, i.e. 32ms more after the interrupt minimum
    wire        hold_done  = (ms_cnt_r >= 17'(pbseq_pkg::FORCED_OFF_MIN_MS
                                              - pbseq_pkg::INT_MIN_MS));
    wire        osc_done   = (osc_cnt_r == 5'(OSC_CYCLES - 1)) & osc_rise;
    wire        pd_done    = off_hold_cap ? osc_done : hold_done;

    // Next state and output levels
    always_comb begin
        state_nxt = state_r;
        clr_timer = 1'h0;
        on_nxt    = on_r;
        int_nxt   = int_r;
        case (state_r)
            pbseq_pkg::PBSEQ_IDLE: begin
                on_nxt  = 1'h0;
                int_nxt = 1'h0;
                clr_timer = 1'h1;
                if (push_fall) state_nxt = pbseq_pkg::PBSEQ_ON_DB;
            end
            pbseq_pkg::PBSEQ_ON_DB: begin
                if (!push_low) begin
                    state_nxt = pbseq_pkg::PBSEQ_IDLE;
                end else if (on_done) begin
                    on_nxt    = 1'h1;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_BLANK;
                end
            end
            pbseq_pkg::PBSEQ_BLANK: begin
                // Inputs not looked at until the window ends
                if (blank_done) begin
                    clr_timer = 1'h1;
                    if (kill_raw_low) begin
                        on_nxt    = 1'h0;
                        state_nxt = pbseq_pkg::PBSEQ_IDLE;
                    end else begin
                        state_nxt = pbseq_pkg::PBSEQ_REL_DB;
                    end
                end
            end
            pbseq_pkg::PBSEQ_REL_DB: begin
                if (push_low) clr_timer = 1'h1;
                else if (rel_done) state_nxt = pbseq_pkg::PBSEQ_RUN;
            end
            pbseq_pkg::PBSEQ_RUN: begin
                clr_timer = 1'h1;
                if (kill_low_r) begin
                    on_nxt    = 1'h0;
                    state_nxt = pbseq_pkg::PBSEQ_LOCK;
                end else if (push_low) begin
                    state_nxt = pbseq_pkg::PBSEQ_OFF_DB;
                end
            end
            pbseq_pkg::PBSEQ_OFF_DB: begin
                if (kill_low_r) begin
                    on_nxt    = 1'h0;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_LOCK;
                end else if (!push_low) begin
                    state_nxt = pbseq_pkg::PBSEQ_RUN;
                end else if (off_done) begin
                    int_nxt   = 1'h1;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_INT_MIN;
                end
            end
            pbseq_pkg::PBSEQ_INT_MIN: begin
                if (kill_low_r) begin
                    on_nxt    = 1'h0;
                    int_nxt   = 1'h0;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_LOCK;
                end else if (imin_done) begin
                    clr_timer = 1'h1;
                    if (push_low) begin
                        state_nxt = pbseq_pkg::PBSEQ_PD;
                    end else begin
                        int_nxt   = 1'h0;
                        state_nxt = pbseq_pkg::PBSEQ_RUN;
                    end
                end
            end
            pbseq_pkg::PBSEQ_PD: begin
                if (kill_low_r) begin
                    on_nxt    = 1'h0;
                    int_nxt   = 1'h0;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_LOCK;
                end else if (!push_low) begin
                    int_nxt   = 1'h0;
                    state_nxt = pbseq_pkg::PBSEQ_RUN;
                end else if (pd_done) begin
                    on_nxt    = 1'h0;
                    int_nxt   = 1'h0;
                    clr_timer = 1'h1;
                    state_nxt = pbseq_pkg::PBSEQ_LOCK;
                end
            end
            pbseq_pkg::PBSEQ_LOCK: begin
                // Button ignored while the supply decays
                if (lock_done) state_nxt = pbseq_pkg::PBSEQ_IDLE;
            end
            default: begin
                state_nxt = pbseq_pkg::PBSEQ_IDLE;
                on_nxt    = 1'h0;
                int_nxt   = 1'h0;
            end
        endcase
    end

    // State and level registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= pbseq_pkg::PBSEQ_IDLE;
            on_r    <= 1'h0;
            int_r   <= 1'h0;
        end else begin
            state_r <= state_nxt;
            on_r    <= on_nxt;
            int_r   <= int_nxt;
        end
    end

    // Millisecond counter, cleared on state entry
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)                              ms_cnt_r <= 17'h00000;
        else if (clr_timer || state_nxt != state_r) ms_cnt_r <= 17'h00000;
        else if (tick && ms_cnt_r != 17'h1FFFF)  ms_cnt_r <= ms_cnt_r + 17'h00001;
    end

    // Oscillator cycle counter for forced power-down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)                     osc_cnt_r <= 5'h00;
        else if (state_r != pbseq_pkg::PBSEQ_PD) osc_cnt_r <= 5'h00;
        else if (osc_rise)              osc_cnt_r <= osc_cnt_r + 5'h01;
    end

    // Registered pin outputs, power_en with build polarity, int_n always active low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_en <= ~EN_ACT_HIGH;
            int_n    <= 1'h1;
        end else begin
            power_en <= EN_ACT_HIGH ? on_nxt : ~on_nxt;
            int_n    <= ~int_nxt;
        end
    end
endmodule : pbseq_top
`default_nettype wire

//--- verification/pbseq_chk_sva.sv
// Checker of the sequencer's port timing
`timescale 1ns/1ps
`default_nettype none
module pbseq_chk #(
    parameter int   TICK_CYC    = 50,
    parameter logic EN_ACT_HIGH = 1'h1
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Watched ports
    input wire logic        push_in_n,
    input wire logic        kill_in_n,
    input wire logic [15:0] on_delay_cap,
    input wire logic        off_hold_cap,
    input wire logic        off_hold_osc,
    input wire logic        power_en,
    input wire logic        int_n
);
    wire logic en;
    int        push_r;
    int        kill_r;
    int        intl_r;
    int        on_r;
    // Enable in its active sense
    assign en = (power_en == EN_ACT_HIGH);
    // Run lengths of low inputs and of enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            push_r <= 0;
            kill_r <= 0;
            intl_r <= 0;
            on_r   <= 0;
        end else begin
            push_r <= push_in_n ? 0 : push_r + 1;
            kill_r <= kill_in_n ? 0 : kill_r + 1;
            intl_r <= int_n ? 0 : intl_r + 1;
            on_r   <= en ? on_r + 1 : 0;
        end
    end
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    out_reset_a: assert property ($rose(rst_n) |-> !en && int_n)
        else $error("outputs active after reset");
    on_debounce_a: assert property ($rose(en) |-> push_r >= (31 + on_delay_cap) * TICK_CYC)
        else $error("enable without full press");
    blank_hold_a: assert property ($fell(en) |-> on_r >= 511 * TICK_CYC)
        else $error("enable dropped in blanking");
    abort_kill_a: assert property (on_r == 513 * TICK_CYC |-> kill_r < on_r)
        else $error("enable kept with kill low");
    int_late_a: assert property ($fell(int_n) |-> on_r >= 573 * TICK_CYC && push_r >= 31 * TICK_CYC)
        else $error("interrupt too early");
    int_min_a: assert property ($rose(int_n) && en |-> intl_r >= 31 * TICK_CYC)
        else $error("interrupt pulse too short");
    int_en_a: assert property (!int_n |-> $past(en))
        else $error("interrupt low while off");
    kill_filt_a: assert property ($fell(en) && $past(int_n) |-> kill_r >= 1490)
        else $error("short kill acted on");
    kill_off_a: assert property (kill_r == 1520 && $past(on_r, 30) > 600 * TICK_CYC |-> !en)
        else $error("kill did not release enable");
    both_release_a: assert property ($fell(en) && !$past(int_n) |-> int_n)
        else $error("interrupt kept after enable release");
endmodule : pbseq_chk
`default_nettype wire

//--- verification/pbseq_proc_model.sv
// Processor model driving the shutdown input
`timescale 1ns/1ps
`default_nettype none
module pbseq_proc_model #(
    parameter logic EN_ACT_HIGH = 1'h1
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Controls
    input wire logic        power_en,
    input wire logic        keep_low,
    input wire logic        pulse_go,
    input wire logic [11:0] pulse_len,
    // Shutdown line
    output logic            kill_in_n
);
    int up_r;
    int pl_r;
    // Boot time and requested low pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 0;
            pl_r <= 0;
        end else begin
            up_r <= (power_en == EN_ACT_HIGH) ? up_r + 1 : 0;
            pl_r <= pulse_go ? int'(pulse_len) : (pl_r > 0 ? pl_r - 1 : 0);
        end
    end
    // Raised once booted, low when unpowered or on request
    assign kill_in_n = (up_r > 100) && !keep_low && (pl_r == 0);
endmodule : pbseq_proc_model
`default_nettype wire

//--- verification/tb_top.sv
// Testbench of the pushbutton power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int   T  = 25;
    localparam logic ON = pbseq_pkg::EN_ACTIVE_HIGH;
    logic        mclk, rst_n, push_in_n, off_hold_osc, keep_low, pulse_go;
    logic        off_hold_cap;
    logic [15:0] on_delay_cap;
    logic [11:0] pulse_len;
    wire logic   kill_in_n, power_en, int_n;
    int          fail_count, samples_checked, odc, k;
    // --------------------------------------------------------------
    // Design, model, clock
    // --------------------------------------------------------------
    pbseq_top #(.TICK_CYC(T)) pbseq_top_inst (.mclk(mclk), .rst_n(rst_n),
        .push_in_n(push_in_n), .kill_in_n(kill_in_n), .on_delay_cap(on_delay_cap),
        .off_hold_cap(off_hold_cap), .off_hold_osc(off_hold_osc), .power_en(power_en),
        .int_n(int_n));
    pbseq_proc_model pbseq_proc_model_inst (.mclk(mclk), .rst_n(rst_n), .power_en(power_en),
        .keep_low(keep_low), .pulse_go(pulse_go), .pulse_len(pulse_len), .kill_in_n(kill_in_n));
    always #10 mclk = ~mclk;
    // Random extension oscillator, counted in PD, acted on only when fitted
    always @(posedge mclk) off_hold_osc <= 1'($urandom_range(1, 0));
    task automatic tk(input int n);
        repeat (n * T) @(posedge mclk);
    endtask : tk
    task automatic chk(input string nm, input logic e, input logic g);
        #1;
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk
    task automatic press(input int n);
        push_in_n <= 1'h0;
        tk(n);
        push_in_n <= 1'h1;
    endtask : press
    task automatic pwr_on;
        push_in_n <= 1'h0;
        for (k = 0; power_en !== ON && k < (45 + odc) * T; k++) @(posedge mclk);
        push_in_n <= 1'h1;
    endtask : pwr_on
    task automatic kill(input logic [11:0] n);
        pulse_len <= n;
        pulse_go  <= 1'h1;
        @(posedge mclk);
        pulse_go  <= 1'h0;
    endtask : kill
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    // Watchdog
    initial begin
        repeat (98000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    // Main sequence
    initial begin
        {mclk, rst_n, pulse_go, off_hold_osc} = 4'h0;
        {push_in_n, keep_low} = 2'h3;
        pulse_len = 12'h000;
        off_hold_cap = 1'h0;
        fail_count = 0;
        samples_checked = 0;
        k = $urandom(18292);
        odc = $urandom_range(3, 0);
        on_delay_cap = 16'(odc);
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        chk("power_en reset", !ON, power_en);
        chk("int_n reset", 1'h1, int_n);
        for (int i = 0; i < 3; i++) begin
            press(i == 0 ? 29 + odc : $urandom_range(25, 5));
            tk(3);
        end
        chk("power_en short press", !ON, power_en);
        pwr_on();
        chk("power_en on", ON, power_en);
        press(200);
        tk(300);
        chk("power_en blanking", ON, power_en);
        tk(20);
        chk("power_en abort", !ON, power_en);
        keep_low <= 1'h0;
        tk(5);
        pwr_on();
        tk(560);
        chk("power_en running", ON, power_en);
        press(20);
        tk(1);
        press(25);
        chk("int_n restarted", 1'h1, int_n);
        push_in_n <= 1'h0;
        for (k = 0; int_n !== 1'h0 && k < 40 * T; k++) @(posedge mclk);
        push_in_n <= 1'h1;
        tk(20);
        chk("int_n minimum", 1'h0, int_n);
        tk(15);
        chk("int_n released", 1'h1, int_n);
        press(77);
        tk(2);
        chk("int_n power-down release", 1'h1, int_n);
        chk("power_en after interrupt", ON, power_en);
        kill(12'h578);
        tk(80);
        chk("power_en short kill", ON, power_en);
        kill(12'h7D0);
        repeat (1600) @(posedge mclk);
        chk("power_en kill", !ON, power_en);
        press(100);
        chk("power_en lockout", !ON, power_en);
        tk(200);
        pwr_on();
        chk("power_en restart", ON, power_en);
        tk(560);
        // Long press with the fixed hold, then held through lockout
        push_in_n <= 1'h0;
        tk(110);
        chk("power_en forced off", !ON, power_en);
        chk("int_n forced off", 1'h1, int_n);
        tk(290);
        push_in_n <= 1'h1;
        chk("power_en held press", !ON, power_en);
        // Long press with the oscillator extension fitted
        off_hold_cap <= 1'h1;
        tk(1);
        pwr_on();
        tk(560);
        push_in_n <= 1'h0;
        for (k = 0; int_n !== 1'h0 && k < 40 * T; k++) @(posedge mclk);
        tk(40);
        chk("power_en osc off", !ON, power_en);
        push_in_n <= 1'h1;
        close_out();
    end
endmodule : tb_top
bind pbseq_top pbseq_chk #(.TICK_CYC(TICK_CYC), .EN_ACT_HIGH(EN_ACT_HIGH)) pbseq_chk_inst (
    .mclk(mclk), .rst_n(rst_n), .push_in_n(push_in_n), .kill_in_n(kill_in_n),
    .on_delay_cap(on_delay_cap), .off_hold_cap(off_hold_cap), .off_hold_osc(off_hold_osc),
    .power_en(power_en), .int_n(int_n));
`default_nettype wire
